// File: rtl/ldwt_defs.vh
// Constants for the long duration wake timer: register offsets, fields,
// reset values and prescaler counts. Definitions only.
`ifndef LDWT_DEFS_VH
`define LDWT_DEFS_VH

`define LDWT_OFF_CTRL      12'h000
`define LDWT_OFF_AFTER_RUN 12'h004
`define LDWT_OFF_WAKE_UP   12'h008
`define LDWT_OFF_COUNT     12'h00c
`define LDWT_OFF_STATUS    12'h010

`define LDWT_CTRL_EN_BIT   0
`define LDWT_CTRL_CAL_BIT  1
`define LDWT_CTRL_FN_LSB   4
`define LDWT_CTRL_FN_MSB   6
`define LDWT_CTRL_CLRF_BIT 8

`define LDWT_ST_MATCH_BIT  0
`define LDWT_ST_OVF_BIT    1
`define LDWT_ST_LOW_POWER_OFF_MODE_BIT  2
`define LDWT_ST_RUN_BIT    3

`define LDWT_AFTER_RUN_RST 16'h0000
`define LDWT_WAKE_UP_RST   24'h000000
`define LDWT_FN_RST        3'h1

`define LDWT_OSC_HZ        32768
`define LDWT_PCLK_HZ       50000000
`define LDWT_PRE1_DIV      16
`define LDWT_PRE2_DIV      2048

`endif

// File: rtl/ldwt_osc_tick.v
// Derives the 32768 Hz oscillator tick as a one-cycle enable from pclk.
// Assumes pclk at the rate given in the constants header.
`include "ldwt_defs.vh"
`default_nettype none
module ldwt_osc_tick #(
    parameter ACC_W = 32
) (
    input  wire pclk,
    input  wire presetn,
    output reg  tick_q
);
    // Fractional accumulator: average tick rate is exactly the oscillator rate.
    localparam [ACC_W-1:0] STEP = `LDWT_OSC_HZ;
    localparam [ACC_W-1:0] LIM  = `LDWT_PCLK_HZ;
    reg [ACC_W-1:0] acc_q;
    wire [ACC_W:0]  sum = {1'b0, acc_q} + {1'b0, STEP};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q  <= {ACC_W{1'b0}};
            tick_q <= 1'b0;
        end else if (sum >= {1'b0, LIM}) begin
            acc_q  <= sum[ACC_W-1:0] - LIM;
            tick_q <= 1'b1;
        end else begin
            acc_q  <= sum[ACC_W-1:0];
            tick_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/ldwt_prescaler.v
// Two-stage prescaler: divide by 16, then optionally by 2048.
// Assumes osc_tick is a one-cycle pulse on pclk.
`include "ldwt_defs.vh"
`default_nettype none
module ldwt_prescaler #(
    parameter PRE1 = `LDWT_PRE1_DIV,
    parameter PRE2 = `LDWT_PRE2_DIV
) (
    input  wire pclk,
    input  wire presetn,
    input  wire run,
    input  wire cal_mode,
    input  wire osc_tick,
    output reg  count_tick_q
);
    reg [3:0]  s1_q;
    reg [10:0] s2_q;
    wire s1_end = osc_tick && (s1_q == PRE1[3:0] - 4'h1);
    wire s2_end = s1_end && (s2_q == PRE2[10:0] - 11'h001);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q         <= 4'h0;
            s2_q         <= 11'h000;
            count_tick_q <= 1'b0;
        end else if (!run) begin
            s1_q         <= 4'h0;
            s2_q         <= 11'h000;
            count_tick_q <= 1'b0;
        end else begin
            if (osc_tick)
                s1_q <= s1_end ? 4'h0 : s1_q + 4'h1;
            if (s1_end)
                s2_q <= s2_end ? 11'h000 : s2_q + 11'h001;
            // Calibration skips the second stage.
            count_tick_q <= cal_mode ? s1_end : s2_end;
        end
    end
endmodule
`default_nettype wire

// File: rtl/ldwt_top.v
// What this block does
// - 24-bit counter advanced from a 32768 Hz oscillator, one second base.
// - Normal prescale divides by 16 then 2048; one count per second.
// - Calibration bypasses the second stage; one count per 488 us.
// - After reset the timer idles until software configures it.
// - In functions 1 to 3, setting the run enable starts counting toward the after-run value.
// - In functions 3 and 4, entering low-power-off starts counting toward the wake-up value.
// - After-run value 16 bits, wake-up 24 bits, both read back.
// - Function 1: after-run match raises a flag and halts the counter.
// - Function 2: after-run match forces low-power-off and halts.
// - Function 3: after-run forces low-power-off, recount, wake on match.
// - Function 4: in low-power-off, wake-up match wakes and halts.
// - Function 5: only all-ones overflow wakes and halts.
// - Function 5: wake by another source leaves the counter running.
// - Timer usable in normal mode with every prescaler option.
//
// Top of the long duration wake timer with an APB register slave.
// Assumes a power manager that reports low-power-off entry and other wakes.
`include "ldwt_defs.vh"
`default_nettype none
module ldwt_top #(
    parameter CNT_W = 24,
    parameter AR_W  = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        low_power_off_mode_entered,
    input  wire        ext_wake,
    output reg         compare_match_flag,
    output reg         enter_low_power_off_mode_req,
    output reg         wake_req
);
    localparam [4:0] ST_IDLE  = 5'b00001;
    localparam [4:0] ST_AFTER = 5'b00010;
    localparam [4:0] ST_WLP   = 5'b00100;
    localparam [4:0] ST_WAKE  = 5'b01000;
    localparam [4:0] ST_HALT  = 5'b10000;

    localparam [2:0] FN1 = 3'h1;
    localparam [2:0] FN2 = 3'h2;
    localparam [2:0] FN3 = 3'h3;
    localparam [2:0] FN4 = 3'h4;
    localparam [2:0] FN5 = 3'h5;

    reg             en_q;
    reg             cal_q;
    reg  [2:0]      fn_q;
    reg  [AR_W-1:0] after_run_q;
    reg  [CNT_W-1:0] wake_up_q;
    reg  [CNT_W-1:0] cnt_q;
    reg  [4:0]      st_q;
    reg             ovf_q;
    reg             low_power_off_mode_q;
    reg             lp_s1_q;
    reg             lp_s2_q;
    reg             lp_s3_q;
    reg             xw_s1_q;
    reg             xw_s2_q;

    wire osc_tick;
    wire cnt_tick;
    wire running = (st_q == ST_AFTER) || (st_q == ST_WAKE);

    ldwt_osc_tick #(
        .ACC_W (32)
    ) u_osc (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_q  (osc_tick)
    );

    ldwt_prescaler #(
        .PRE1 (`LDWT_PRE1_DIV),
        .PRE2 (`LDWT_PRE2_DIV)
    ) u_pre (
        .pclk         (pclk),
        .presetn      (presetn),
        .run          (running),
        .cal_mode     (cal_q),
        .osc_tick     (osc_tick),
        .count_tick_q (cnt_tick)
    );

    // Power-state inputs come from another domain and are synchronised.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_s1_q <= 1'b0;
            lp_s2_q <= 1'b0;
            lp_s3_q <= 1'b0;
            xw_s1_q <= 1'b0;
            xw_s2_q <= 1'b0;
        end else begin
            lp_s1_q <= low_power_off_mode_entered;
            lp_s2_q <= lp_s1_q;
            lp_s3_q <= lp_s2_q;
            xw_s1_q <= ext_wake;
            xw_s2_q <= xw_s1_q;
        end
    end

    // The third stage marks the rising edge; it resets to the idle level,
    // so no false entry is seen right after reset.
    wire lp_rise = lp_s2_q && !lp_s3_q;

    wire wr_acc = psel && penable && pwrite;
    wire rd_set = psel && !penable && !pwrite;
    wire wr_ctrl = wr_acc && (paddr == `LDWT_OFF_CTRL);
    wire clr_flags = wr_ctrl && pwdata[`LDWT_CTRL_CLRF_BIT];

    // Matches look at the value the counter is about to take, so the
    // halt and the event land on the same edge as the final count.
    wire [CNT_W-1:0] cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    wire ar_hit = cnt_tick && (cnt_inc[AR_W-1:0] == after_run_q)
                  && (cnt_inc[CNT_W-1:AR_W] == {(CNT_W-AR_W){1'b0}});
    wire wu_hit = cnt_tick && (cnt_inc == wake_up_q);
    wire ov_hit = cnt_tick && (cnt_inc == {CNT_W{1'b1}});

    reg [4:0]       st_d;
    reg [CNT_W-1:0] cnt_d;
    reg             match_set;
    reg             lp_req_set;
    reg             wake_set;
    reg             ovf_set;

    always @* begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        match_set  = 1'b0;
        lp_req_set = 1'b0;
        wake_set   = 1'b0;
        ovf_set    = 1'b0;
        case (st_q)
            ST_IDLE: begin
                // Nothing counts until software enables; functions 4 and 5 also wait for low-power entry.
                if (en_q && fn_q != FN4 && fn_q != FN5) begin
                    st_d  = ST_AFTER;
                    cnt_d = {CNT_W{1'b0}};
                end else if (en_q && lp_rise) begin
                    st_d  = ST_WAKE;
                    cnt_d = {CNT_W{1'b0}};
                end
            end
            ST_AFTER: begin
                if (!en_q) begin
                    st_d = ST_HALT;
                end else if (cnt_tick) begin
                    cnt_d = cnt_inc;
                    if (ar_hit) begin
                        case (fn_q)
                            FN1: begin
                                match_set = 1'b1;
                                st_d      = ST_HALT;
                            end
                            FN2: begin
                                lp_req_set = 1'b1;
                                st_d       = ST_HALT;
                            end
                            default: begin
                                lp_req_set = 1'b1;
                                st_d       = ST_WLP;
                            end
                        endcase
                    end
                end
            end
            ST_WLP: begin
                if (!en_q) begin
                    st_d = ST_HALT;
                end else if (lp_rise) begin
                    st_d  = ST_WAKE;
                    cnt_d = {CNT_W{1'b0}};
                end
            end
            ST_WAKE: begin
                if (!en_q) begin
                    st_d = ST_HALT;
                end else if (cnt_tick) begin
                    cnt_d = cnt_inc;
                    if (fn_q == FN5) begin
                        // Other wake sources do not stop the count.
                        if (ov_hit) begin
                            ovf_set  = 1'b1;
                            wake_set = 1'b1;
                            st_d     = ST_HALT;
                        end
                    end else if (wu_hit) begin
                        match_set = 1'b1;
                        wake_set  = 1'b1;
                        st_d      = ST_HALT;
                    end
                end
            end
            ST_HALT: begin
                // Count stays readable; re-enable restarts from the idle state.
                if (!en_q)
                    st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= ST_IDLE;
            cnt_q <= {CNT_W{1'b0}};
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Configuration registers; not touched by power-state changes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q        <= 1'b0;
            cal_q       <= 1'b0;
            fn_q        <= `LDWT_FN_RST;
            after_run_q <= `LDWT_AFTER_RUN_RST;
            wake_up_q   <= `LDWT_WAKE_UP_RST;
        end else if (wr_acc) begin
            case (paddr)
                `LDWT_OFF_CTRL: begin
                    en_q  <= pwdata[`LDWT_CTRL_EN_BIT];
                    cal_q <= pwdata[`LDWT_CTRL_CAL_BIT];
                    fn_q  <= pwdata[`LDWT_CTRL_FN_MSB:`LDWT_CTRL_FN_LSB];
                end
                `LDWT_OFF_AFTER_RUN: after_run_q <= pwdata[AR_W-1:0];
                `LDWT_OFF_WAKE_UP:   wake_up_q <= pwdata[CNT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky match and overflow flags: a set in the same cycle as a clear wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_match_flag <= 1'b0;
            ovf_q              <= 1'b0;
            low_power_off_mode_q            <= 1'b0;
            enter_low_power_off_mode_req    <= 1'b0;
            wake_req           <= 1'b0;
        end else begin
            compare_match_flag <= match_set | (compare_match_flag & ~clr_flags);
            ovf_q              <= ovf_set | (ovf_q & ~clr_flags);
            enter_low_power_off_mode_req    <= lp_req_set;
            wake_req           <= wake_set;
            if (lp_rise)
                low_power_off_mode_q <= 1'b1;
            else if (wake_set || xw_s2_q)
                low_power_off_mode_q <= 1'b0;
        end
    end

    // APB slave: zero wait states, unmapped addresses answer an error.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable &&
                       (paddr != `LDWT_OFF_CTRL) &&
                       (paddr != `LDWT_OFF_AFTER_RUN) &&
                       (paddr != `LDWT_OFF_WAKE_UP) &&
                       (paddr != `LDWT_OFF_COUNT) &&
                       (paddr != `LDWT_OFF_STATUS);
            if (rd_set) begin
                case (paddr)
                    `LDWT_OFF_CTRL:
                        prdata <= {23'h000000, 1'b0, 1'b0, fn_q,
                                   2'h0, cal_q, en_q};
                    `LDWT_OFF_AFTER_RUN:
                        prdata <= {16'h0000, after_run_q};
                    `LDWT_OFF_WAKE_UP:
                        prdata <= {8'h00, wake_up_q};
                    `LDWT_OFF_COUNT:
                        prdata <= {8'h00, cnt_q};
                    `LDWT_OFF_STATUS:
                        prdata <= {28'h0000000, running, low_power_off_mode_q, ovf_q,
                                   compare_match_flag};
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/ldwt_checker.sv
// Pin-level assertions for the long duration wake timer top.
// Assumes one clock, pclk, and the asynchronous active-low presetn.
`default_nettype none
module ldwt_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        low_power_off_mode_entered,
    input wire logic        ext_wake,
    input wire logic        compare_match_flag,
    input wire logic        enter_low_power_off_mode_req,
    input wire logic        wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_after_setup: assert property (
        psel && !penable |=> pready) else $error("no ready after setup");
    chk_ready_one_cycle: assert property (
        pready |=> !pready) else $error("ready held too long");
    chk_err_zero_data: assert property (
        pslverr |-> pready && prdata == 32'h0) else $error("bad error data");
    chk_reset_idle: assert property (
        $rose(presetn) |-> !compare_match_flag && !enter_low_power_off_mode_req
        && !wake_req) else $error("timer busy after reset");
    chk_low_power_off_mode_pulse: assert property (
        enter_low_power_off_mode_req |=> !enter_low_power_off_mode_req) else $error("long entry pulse");
    chk_wake_pulse: assert property (
        wake_req |=> !wake_req) else $error("long wake pulse");
    chk_flag_sticky: assert property (
        compare_match_flag && !(psel && penable && pwrite
        && paddr == 12'h000 && pwdata[8]) |=> compare_match_flag)
        else $error("match flag dropped");
    chk_entry_awake: assert property (
        enter_low_power_off_mode_req |-> !low_power_off_mode_entered) else $error("entry while asleep");
    chk_wake_asleep: assert property (
        wake_req |-> low_power_off_mode_entered && $past(low_power_off_mode_entered, 2))
        else $error("wake while awake");
endmodule
bind ldwt_top ldwt_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_off_mode_entered(low_power_off_mode_entered), .ext_wake(ext_wake),
    .compare_match_flag(compare_match_flag),
    .enter_low_power_off_mode_req(enter_low_power_off_mode_req), .wake_req(wake_req));
`default_nettype wire

// File: verif/ldwt_power_model.sv
// Power manager model: enters low-power-off on request, leaves on wake.
// Assumes the bench pulses go_low_power_off_mode and holds other_wake for a while.
`default_nettype none
module ldwt_power_model #(
    parameter int ENTRY_DLY = 4
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic enter_low_power_off_mode_req,
    input  wire logic wake_req,
    input  wire logic go_low_power_off_mode,
    input  wire logic other_wake,
    output var logic  low_power_off_mode_entered,
    output var logic  ext_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_power_off_mode_entered <= 1'b0;
            ext_wake      <= 1'b0;
            cnt           <= 0;
        end else begin
            ext_wake <= other_wake;
            if (enter_low_power_off_mode_req || go_low_power_off_mode) begin
                cnt <= ENTRY_DLY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            if (wake_req || other_wake) begin
                low_power_off_mode_entered <= 1'b0;
            end else if (cnt == 1) begin
                low_power_off_mode_entered <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/ldwt_tb_top.sv
// Self-checking bench for the long duration wake timer over APB.
// Assumes calibration mode so that one count takes about 24400 cycles.
`default_nettype none
module ldwt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'hbb0b, rd;
    logic        er, go_low_power_off_mode = 0, other_wake = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, low_power_off_mode_entered, ext_wake;
    wire         compare_match_flag, enter_low_power_off_mode_req, wake_req;
    int          n_mismatch = 0, comparisons = 0;
    initial forever #10 pclk = ~pclk;
    ldwt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_power_off_mode_entered(low_power_off_mode_entered), .ext_wake(ext_wake),
        .compare_match_flag(compare_match_flag),
        .enter_low_power_off_mode_req(enter_low_power_off_mode_req), .wake_req(wake_req));
    ldwt_power_model u_pm (.pclk(pclk), .presetn(presetn),
        .enter_low_power_off_mode_req(enter_low_power_off_mode_req), .wake_req(wake_req),
        .go_low_power_off_mode(go_low_power_off_mode), .other_wake(other_wake),
        .low_power_off_mode_entered(low_power_off_mode_entered), .ext_wake(ext_wake));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic pick(input int k);
        if (k == 0) return compare_match_flag;
        if (k == 1) return enter_low_power_off_mode_req;
        return wake_req;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer; read data and error are taken when pready is seen.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_on(input int k);
        int i;
        for (i = 0; i < 26000 && pick(k) !== 1'b1; i++) @(posedge pclk);
    endtask
    task automatic low_power_off_mode_pulse;
        go_low_power_off_mode <= 1'b1;
        @(posedge pclk);
        go_low_power_off_mode <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 0); check(rd, 32'h10);
        apb(0, 12'h004, 0); check(rd, 32'h0);
        apb(0, 12'h008, 0); check(rd, 32'h0);
        apb(0, 12'h010, 0); check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            apb(1, 12'h004, seed);
            apb(0, 12'h004, 0); check(rd, {16'h0, seed[15:0]});
            apb(1, 12'h008, ~seed);
            apb(0, 12'h008, 0); check(rd, {8'h0, ~seed[23:0]});
        end
        apb(1, 12'h00c, seed);
        apb(0, 12'h00c, 0); check(rd, 32'h0);
        apb(0, 12'h020, 0); check({31'h0, er}, 32'h1);
        apb(1, 12'h004, 1);
        apb(1, 12'h000, 32'h13);
        wait_on(0); check({31'h0, pick(0)}, 32'h1);
        apb(0, 12'h010, 0); check(rd & 32'h9, 32'h1);
        apb(1, 12'h000, 32'h102);
        apb(0, 12'h00c, 0); check(rd, 32'h1);
        check({31'h0, compare_match_flag}, 32'h0);
        apb(1, 12'h008, 1);
        apb(1, 12'h000, 32'h33);
        wait_on(1); check({31'h0, pick(1)}, 32'h1);
        wait_on(2); check({31'h0, pick(2)}, 32'h1);
        apb(0, 12'h000, 0); check(rd & 32'h73, 32'h33);
        apb(0, 12'h008, 0); check(rd, 32'h1);
        apb(1, 12'h000, 32'h152);
        apb(1, 12'h000, 32'h53);
        low_power_off_mode_pulse();
        apb(0, 12'h010, 0); check(rd & 32'hc, 32'hc);
        other_wake <= 1'b1;
        repeat (20) @(posedge pclk);
        other_wake <= 1'b0;
        apb(0, 12'h010, 0); check(rd & 32'hc, 32'h8);
        apb(1, 12'h000, 32'h42);
        apb(1, 12'h000, 32'h43);
        low_power_off_mode_pulse();
        wait_on(2); check({31'h0, pick(2)}, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
